// file: verilog/wake_pkg.sv
`default_nettype none
package wake_pkg;

    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int N_WAKE        = 8;
    localparam int WAKE_IRQ_BASE = 32;

    // ---------------------------------------------------------------
    // register byte addresses
    // ---------------------------------------------------------------
    localparam logic [31:0] ADDR_EDGE       = 32'h4004_8210;
    localparam logic [31:0] ADDR_ENABLE     = 32'h4004_8214;
    localparam logic [31:0] ADDR_CLEAR      = 32'h4004_8218;
    localparam logic [31:0] ADDR_PENDING    = 32'h4004_821C;
    localparam logic [31:0] ADDR_EVT_STATUS = 32'h4004_8220;
    localparam logic [31:0] ADDR_EVT_MASK   = 32'h4004_8224;

    // ---------------------------------------------------------------
    // field layout, shared by every register of the bank
    // ---------------------------------------------------------------
    localparam int FLD_P2_IN8     = 0;
    localparam int FLD_P2_IN9_LO  = 1;
    localparam int FLD_P2_IN11_HI = 3;
    localparam int FLD_P3_IN0     = 4;
    localparam int FLD_P3_IN1_LO  = 5;
    localparam int FLD_P3_IN3_HI  = 7;
    localparam int BYTE_LANE_LOW  = 0;

    // ---------------------------------------------------------------
    // reset values and encodings
    // ---------------------------------------------------------------
    localparam logic [7:0]  ENABLE_RESET = 8'h00;
    localparam logic [7:0]  EDGE_RESET   = 8'h00;
    localparam logic [7:0]  MASK_RESET   = 8'h00;
    localparam logic [7:0]  EVT_RESET    = 8'h00;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [7:0]  BYTE_ONES    = 8'hFF;
    localparam logic [23:0] RSVD_ZERO    = 24'h00_0000;
    localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
    localparam logic        EDGE_FALL    = 1'b0;
    localparam logic        EDGE_RISE    = 1'b1;
    localparam logic [1:0]  WARM_DONE    = 2'h3;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic edge_rise;
    } wake_cfg_t;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic        we;
        logic [3:0]  sel;
    } wb_req_t;

endpackage
`default_nettype wire

// file: verilog/wake_start_cell.sv
`timescale 1ns/1ps
`default_nettype none
module wake_start_cell
    import wake_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      rst,
    input  wire logic      pin,
    input  wire wake_cfg_t cfg,
    input  wire logic      clear,
    output logic           capture,
    output logic           pending
);

    // ---------------------------------------------------------------
    // pin synchroniser
    // ---------------------------------------------------------------
    logic       sync_a;
    logic       sync_q;
    logic       prev_q;
    logic [1:0] warm;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            warm   <= 2'h0;
        end else begin
            sync_a <= pin;
            sync_q <= sync_a;
            prev_q <= sync_q;
            if (warm != WARM_DONE) begin
                warm <= warm + 2'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // edge capture
    // ---------------------------------------------------------------
    // edges are ignored until the pipe holds real pin levels
    wire rise_seen = sync_q & ~prev_q;
    wire fall_seen = ~sync_q & prev_q;
    wire edge_hit  = (cfg.edge_rise == EDGE_RISE) ? rise_seen : fall_seen; // R09
    assign capture = edge_hit & cfg.enable & (warm == WARM_DONE); // R04

    // a new edge beats a clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pending <= 1'b0;
        end else if (capture) begin
            pending <= 1'b1; // R04
        end else if (clear) begin
            pending <= 1'b0; // R03
        end
    end

    chk_edge_polarity: assert property (@(posedge clock) disable iff (rst) // R09
        capture |-> (sync_q == cfg.edge_rise) && (prev_q != sync_q))
        else $error("capture on wrong edge");

endmodule
`default_nettype wire

// file: verilog/wake_start_bank.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R01] enable register: bit0 p2 in8, bits3:1 p2 in11..9, bit4 p3 in0, 7:5 p3 in3..1
// [R02] enable bit 1 allows a start signal, 0 blocks; resets to 0
// [R03] writing 1 to a clear bit drops that input's latched state; 0 does nothing
// [R04] each pin's own edge registers a start signal
// [R05] a registered start signal raises that input's wake-up interrupt
// [R06] software clears an input's latched state before relying on it
// [R07] status reads 1 for an enabled pending input, 0 otherwise, enable layout
// [R08] status bit 4 is p3 in0, bits 7:5 are p3 in3..1
// [R09] edge-select bit 0 picks falling edge, 1 picks rising edge
// [R10] input bit n drives wake interrupt line 32+n, bits 0..7 to lines 32..39
// [R11] bits 31:8 of every register read zero and ignore writes
module wake_start_bank
    import wake_pkg::*;
#(
    parameter int NUM_WAKE = N_WAKE
)(
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [31:0]         wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [NUM_WAKE-1:0] wake_pin,
    output logic      [NUM_WAKE-1:0] wake_irq,
    output logic                     irq
);

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wb_req_t req;
    assign req.adr = wb_adr_i;
    assign req.dat = wb_dat_i;
    assign req.we  = wb_we_i;
    assign req.sel = wb_sel_i;

    // one access per request: the ack cycle itself is not taken again
    wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire low_en = req.sel[BYTE_LANE_LOW];
    wire wr     = access & req.we & low_en;
    wire rd     = access & ~req.we;

    wire hit_edge    = (req.adr == ADDR_EDGE);
    wire hit_enable  = (req.adr == ADDR_ENABLE);
    wire hit_clear   = (req.adr == ADDR_CLEAR);
    wire hit_pending = (req.adr == ADDR_PENDING);
    wire hit_status  = (req.adr == ADDR_EVT_STATUS);
    wire hit_mask    = (req.adr == ADDR_EVT_MASK);

    wire [7:0] wr_byte = req.dat[7:0];

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic [7:0] edge_sel;
    logic [7:0] enable;
    logic [7:0] evt_mask;
    logic [7:0] evt_status;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            edge_sel <= EDGE_RESET;
            enable   <= ENABLE_RESET; // R02
            evt_mask <= MASK_RESET;
        end else begin
            if (wr && hit_edge) begin
                edge_sel <= wr_byte; // R09
            end
            if (wr && hit_enable) begin
                enable <= wr_byte; // R01
            end
            if (wr && hit_mask) begin
                evt_mask <= wr_byte;
            end
        end
    end

    // ---------------------------------------------------------------
    // start cells
    // ---------------------------------------------------------------
    // the clear strobe is a pulse; a 0 bit leaves that cell alone
    wire [7:0] clear_vec = (wr && hit_clear) ? wr_byte : BYTE_ZERO; // R03
    logic [NUM_WAKE-1:0] capture;
    logic [NUM_WAKE-1:0] pending;

    genvar g;
    generate
        for (g = 0; g < NUM_WAKE; g++) begin : g_cell
            wake_cfg_t cell_cfg;
            assign cell_cfg.enable    = enable[g];
            assign cell_cfg.edge_rise = edge_sel[g];
            wake_start_cell u_cell (
                .clock   (clock),
                .rst     (rst),
                .pin     (wake_pin[g]),
                .cfg     (cell_cfg),
                .clear   (clear_vec[g]),
                .capture (capture[g]),
                .pending (pending[g])
            );
        end
    endgenerate

    // disabled inputs never show pending; stale state stays hidden
    // only until software enables the input again, which is why R06 clears it first
    wire [7:0] status_view = pending & enable; // R07 R06
    // line n of this vector is wake interrupt 32+n
    assign wake_irq = status_view; // R05 R10

    // ---------------------------------------------------------------
    // event status and interrupt
    // ---------------------------------------------------------------
    wire [7:0] events   = capture & ~pending;
    wire [7:0] rd_clear = (rd && hit_status) ? BYTE_ONES : BYTE_ZERO;
    // set wins over the read-clear in the same cycle
    wire [7:0] next_evt = (evt_status & ~rd_clear) | events;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            evt_status <= EVT_RESET;
        end else begin
            evt_status <= next_evt;
        end
    end

    assign irq = |(evt_status & evt_mask);

    // ---------------------------------------------------------------
    // read data and ack
    // ---------------------------------------------------------------
    // clear register is write-only; unmapped addresses answer zero
    wire [7:0] rd_byte =
        hit_edge    ? edge_sel   :
        hit_enable  ? enable     :
        hit_pending ? status_view : // R08
        hit_status  ? evt_status :
        hit_mask    ? evt_mask   :
                      BYTE_ZERO;
    wire [31:0] next_rdata = {RSVD_ZERO, rd_byte}; // R11

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= WORD_ZERO;
        end else begin
            wb_ack_o <= access;
            if (rd) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over two cycles");

    chk_ack_answer: assert property (access |=> wb_ack_o)
        else $error("request not answered next cycle");

    chk_enable_write: assert property ( // R01
        (wr && hit_enable) |=> (enable == $past(wr_byte)))
        else $error("enable write lost");

    chk_enable_readback: assert property ( // R02
        (rd && hit_enable) |=> (wb_dat_o == {RSVD_ZERO, $past(enable)}))
        else $error("enable readback wrong");

    chk_clear_drops: assert property ( // R03
        (wr && hit_clear) |=> ((pending & $past(wr_byte) & ~$past(capture)) == BYTE_ZERO))
        else $error("cleared input still pending");

    chk_clear_keeps: assert property ( // R03
        (wr && hit_clear) |=>
            ((($past(pending) & ~$past(wr_byte)) & ~pending) == BYTE_ZERO))
        else $error("zero bit of clear dropped state");

    chk_capture_latch: assert property ( // R04
        (|capture) |=> ((pending & $past(capture)) == $past(capture)))
        else $error("captured edge not latched");

    chk_wake_raise: assert property ( // R05
        (|(capture & enable)) |=>
            ((wake_irq & $past(capture & enable)) == ($past(capture & enable) & enable)))
        else $error("wake line not raised after capture");

    chk_status_read: assert property ( // R07
        (rd && hit_pending) |=> (wb_dat_o == {RSVD_ZERO, $past(pending & enable)}))
        else $error("pending status readback wrong");

    chk_clear_reads_zero: assert property ( // R11
        (rd && (hit_clear || !(hit_edge || hit_enable || hit_pending || hit_status
                               || hit_mask))) |=> (wb_dat_o == WORD_ZERO))
        else $error("write-only or unmapped read not zero");

    chk_evt_sticky: assert property (
        (|events) |=> ((evt_status & $past(events)) == $past(events))
            && (irq == |(evt_status & evt_mask)))
        else $error("event not held sticky");

endmodule
`default_nettype wire

// file: tb/wake_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module wake_pin_model
    import wake_pkg::*;
#(
    parameter int HOLD = 3
)(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic [N_WAKE-1:0] level_req,
    output logic      [N_WAKE-1:0] wake_pin
);
    // ---------------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------------
    // a new level waits until the old one stood HOLD cycles,
    // so no glitch shorter than the sampler can see reaches the pins
    int unsigned age;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_pin <= BYTE_ZERO;
            age      <= 0;
        end else if (level_req !== wake_pin && age >= HOLD) begin
            wake_pin <= level_req;
            age      <= 0;
        end else if (age < HOLD) begin
            age <= age + 1;
        end
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import wake_pkg::*;
;
    logic        clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq;
    logic [31:0] adr = WORD_ZERO, dat = WORD_ZERO, dat_o, q;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  pin_req = BYTE_ZERO, wake_pin, wake_irq;
    int          fail_count = 0, check_count = 0;

    wake_start_bank wake_start_bank_i (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wake_pin(wake_pin), .wake_irq(wake_irq),
        .irq(irq));
    wake_pin_model wake_pin_model_i (.clock(clock), .rst(rst), .level_req(pin_req),
        .wake_pin(wake_pin));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // classic cycle: ack is sampled at a rising edge, then the request drops
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n = 0;
        @(posedge clock);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) check(1'b0, 1'b1, "ack timeout");
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, WORD_ZERO, 4'hF);
        check(q, exp, what);
    endtask

    task automatic settle();
        repeat (10) @(posedge clock);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_reset();
        rd_chk(ADDR_ENABLE, WORD_ZERO, "enable reset");
        rd_chk(ADDR_EDGE, WORD_ZERO, "edge reset");
        rd_chk(ADDR_PENDING, WORD_ZERO, "pending reset");
        rd_chk(ADDR_CLEAR, WORD_ZERO, "clear reads zero");
        rd_chk(32'h4004_8228, WORD_ZERO, "unmapped read");
        check({24'h0, wake_irq}, WORD_ZERO, "irq lines reset");
        $display("test reset done");
    endtask

    task automatic test_regs();
        wb(1'b1, ADDR_ENABLE, 32'hFFFF_FFFF, 4'hF);
        rd_chk(ADDR_ENABLE, 32'h0000_00FF, "reserved bits");
        wb(1'b1, ADDR_ENABLE, WORD_ZERO, 4'hE);
        rd_chk(ADDR_ENABLE, 32'h0000_00FF, "sel0 low write");
        wb(1'b1, ADDR_ENABLE, 32'h0000_005A, 4'h1);
        rd_chk(ADDR_ENABLE, 32'h0000_005A, "enable pattern");
        wb(1'b1, ADDR_PENDING, 32'h0000_00FF, 4'hF);
        rd_chk(ADDR_PENDING, WORD_ZERO, "pending read only");
        $display("test regs done");
    endtask

    // one input at a time, rising edges, event masked off
    task automatic test_each_input();
        logic [7:0] b;
        wb(1'b1, ADDR_EDGE, 32'h0000_00FF, 4'hF);
        for (int i = 0; i < N_WAKE; i++) begin
            b = 8'h01 << i;
            wb(1'b1, ADDR_ENABLE, {24'h0, b}, 4'hF);
            wb(1'b1, ADDR_CLEAR, 32'h0000_00FF, 4'hF);
            rd_chk(ADDR_EVT_STATUS, {24'h0, 8'h00}, "status after clear");
            pin_req[i] <= 1'b1;
            settle();
            check({24'h0, wake_irq}, {24'h0, b}, "irq line of input");
            check({31'h0, irq}, WORD_ZERO, "masked event");
            rd_chk(ADDR_PENDING, {24'h0, b}, "pending bit");
            rd_chk(ADDR_EVT_STATUS, {24'h0, b}, "event bit");
            wb(1'b1, ADDR_CLEAR, {24'h0, ~b}, 4'hF);
            rd_chk(ADDR_PENDING, {24'h0, b}, "clear with zero");
            wb(1'b1, ADDR_CLEAR, {24'h0, b}, 4'hF);
            rd_chk(ADDR_PENDING, WORD_ZERO, "clear with one");
            check({24'h0, wake_irq}, WORD_ZERO, "irq line cleared");
        end
        $display("test each input done");
    endtask

    // all pins fall, only the enabled one is kept
    task automatic test_falling_disabled();
        wb(1'b1, ADDR_EDGE, WORD_ZERO, 4'hF);
        wb(1'b1, ADDR_ENABLE, 32'h0000_0001, 4'hF);
        wb(1'b1, ADDR_CLEAR, 32'h0000_00FF, 4'hF);
        pin_req <= BYTE_ZERO;
        settle();
        check({24'h0, wake_irq}, 32'h0000_0001, "falling edge capture");
        wb(1'b1, ADDR_ENABLE, 32'h0000_00FF, 4'hF);
        rd_chk(ADDR_PENDING, 32'h0000_0001, "disabled edge ignored");
        rd_chk(ADDR_EVT_STATUS, 32'h0000_0001, "falling event");
        wb(1'b1, ADDR_CLEAR, 32'h0000_00FF, 4'hF);
        $display("test falling done");
    endtask

    task automatic test_interrupt();
        wb(1'b1, ADDR_EVT_MASK, 32'h0000_00FF, 4'hF);
        rd_chk(ADDR_EVT_MASK, 32'h0000_00FF, "mask readback");
        wb(1'b1, ADDR_EDGE, 32'h0000_00FF, 4'hF);
        wb(1'b1, ADDR_ENABLE, 32'h0000_0010, 4'hF);
        pin_req[FLD_P3_IN0] <= 1'b1;
        settle();
        check({31'h0, irq}, 32'h0000_0001, "irq raised");
        rd_chk(ADDR_PENDING, 32'h0000_0010, "port3 in0 bit");
        rd_chk(ADDR_EVT_STATUS, 32'h0000_0010, "event read");
        @(posedge clock);
        check({31'h0, irq}, WORD_ZERO, "irq after read clear");
        rd_chk(ADDR_EVT_STATUS, WORD_ZERO, "event cleared");
        $display("test interrupt done");
    endtask

    // ---------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ---------------------------------------------------------------
    initial begin
        forever #4 clock = ~clock;
    end

    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        test_reset();
        test_regs();
        test_each_input();
        test_falling_disabled();
        test_interrupt();
        tally_and_finish();
    end

    // the tests need well under 2000 cycles; this only catches a hang
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
